// ===== mmq_axis.sv
`timescale 1ns/10ps
module mmq_axis
(
    input wire logic clk,
    input wire logic rst,
    mmq_axis_if.axis port
);
    localparam int EW = mmq_pkg::EDGE_W;
    localparam int PW = mmq_pkg::POS_W;

    logic [EW-1:0] remaining;
    logic reverse;
    logic continuous;
    logic [EW-1:0] magnitude;
    logic [EW-1:0] speed_ext;
    logic [EW-1:0] step_size;
    logic moving;

    // Size of this tick's step, limited by what is left of a non-continuous move
    always_comb
    begin
        magnitude = remaining[EW-1] ? (~remaining + EW'(1)) : remaining;
        speed_ext = (port.speed == '0) ? EW'(1) : EW'(port.speed);
        if (continuous)
            step_size = speed_ext;
        else
            step_size = (magnitude < speed_ext) ? magnitude : speed_ext;
        moving = port.step && port.busy && !(continuous && port.halt);
    end

    // Active stage: holds the executing move until it completes
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            port.busy <= 1'h0;
            port.done <= 1'h0;
            remaining <= '0;
            reverse <= 1'h0;
            continuous <= 1'h0;
        end
        else
        begin
            port.done <= 1'h0;
            if (port.load)
            begin
                port.busy <= 1'h1;
                continuous <= port.continuous;
                remaining <= port.edges;
                reverse <= port.edges[EW-1];
            end
            else if (port.step && port.busy)
            begin
                if (continuous)
                begin
                    if (port.halt)
                    begin
                        port.busy <= 1'h0;
                        port.done <= 1'h1;
                    end
                end
                else
                begin
                    remaining <= reverse ? remaining + step_size : remaining - step_size;
                    if (step_size == magnitude)
                    begin
                        port.busy <= 1'h0;
                        port.done <= 1'h1;
                    end
                end
            end
        end
    end

    // Axis position in encoder edges, advanced once per tick
    always_ff @(posedge clk)
    begin
        if (rst)
            port.position <= mmq_pkg::POS_RESET;
        else if (moving)
            port.position <= reverse ? port.position - PW'(step_size)
                                     : port.position + PW'(step_size);
    end
endmodule

// ===== mmq_axis_if.sv
`timescale 1ns/10ps
interface mmq_axis_if;
    logic load;
    logic [mmq_pkg::EDGE_W-1:0] edges;
    logic continuous;
    logic step;
    logic halt;
    logic [mmq_pkg::SPEED_W-1:0] speed;
    logic busy;
    logic done;
    logic [mmq_pkg::POS_W-1:0] position;

    modport main (
        output load,
        output edges,
        output continuous,
        output step,
        output halt,
        output speed,
        input busy,
        input done,
        input position
    );

    modport axis (
        input load,
        input edges,
        input continuous,
        input step,
        input halt,
        input speed,
        output busy,
        output done,
        output position
    );
endinterface

// ===== mmq_pkg.sv
package mmq_pkg;

    // Sizes of the sequencer
    localparam int NUM_TASKS = 5;
    localparam int NUM_AXES = 4;
    localparam int TASK_DEPTH = 2;

    // Field widths
    localparam int TYPE_W = 8;
    localparam int TARGET_W = 32;
    localparam int FRAC_W = 16;
    localparam int EDGE_W = TARGET_W - FRAC_W + 1;
    localparam int SPEED_W = 16;
    localparam int POS_W = 32;

    // Move identity codes
    localparam logic [TYPE_W-1:0] MT_IDLE = 8'h00;
    localparam logic [TYPE_W-1:0] MT_MOVE = 8'h01;
    localparam logic [TYPE_W-1:0] MT_FORWARD = 8'h0A;
    localparam logic [TYPE_W-1:0] MT_REVERSE = 8'h0B;

    // Servo tick timing
    localparam int CLK_KHZ = 20000;
    localparam int SERVO_TICK_US = 1000;
    localparam int TICK_CYCLES = (SERVO_TICK_US * CLK_KHZ) / 1000;

    // Fraction above which an edge count rounds up, in tenths
    localparam int ROUND_UP_TENTHS = 9;
    localparam logic [FRAC_W-1:0] ROUND_UP_THRESH =
        FRAC_W'((ROUND_UP_TENTHS * (1 << FRAC_W)) / 10);

    // Values after reset
    localparam logic [POS_W-1:0] POS_RESET = 32'h0000_0000;

    // Sequencer phases within one servo tick
    typedef enum logic [3:0] {
        S_IDLE = 4'h1,
        S_SEQ = 4'h2,
        S_LOAD = 4'h4,
        S_RUN = 4'h8
    } mmq_state_e;

    // Target in fixed point to whole encoder edges
    function automatic logic [EDGE_W-1:0] to_edges(input logic [TARGET_W-1:0] target);
        logic [EDGE_W-1:0] whole;
        whole = {target[TARGET_W-1], target[TARGET_W-1:FRAC_W]};
        if (target[FRAC_W-1:0] > ROUND_UP_THRESH)
        begin
            whole = whole + EDGE_W'(1);
        end
        return whole;
    endfunction

    // Moves that run until halted
    function automatic logic is_continuous(input logic [TYPE_W-1:0] move_type);
        return (move_type == MT_FORWARD) || (move_type == MT_REVERSE);
    endfunction

endpackage

// ===== mmq_sequencer.sv
`timescale 1ns/10ps
// Contract
// - Each program task owns its own buffers for issued move commands.
// - Every axis has exactly two stages, active move and queued move.
// - Active type output shows the executing move code, 10 for forward.
// - A queued move starts only once the active move on that axis ended.
// - A move loads only when the active stages of all its axes are empty.
// - A task with full buffers is stalled and accepts no more commands.
// - Queue full flag is true exactly while that task's buffers are full.
// - Each tick, a waiting move goes into free queued stages, all axes together.
// - Task buffer entry is freed once its move went to the queued stages.
// - After sequencing, queued moves go to free active stages, queued freed.
// - Active moves run every tick and the active stage frees when done.
// - Edge conversion rounds up when fraction exceeds 0.9, else down.
// - Each axis runs its own logic with its own speed, independently.
module mmq_sequencer
#(
    parameter int NUM_TASKS = mmq_pkg::NUM_TASKS,
    parameter int NUM_AXES = mmq_pkg::NUM_AXES,
    parameter int DEPTH = mmq_pkg::TASK_DEPTH,
    parameter int TICK_CYCLES = mmq_pkg::TICK_CYCLES
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [NUM_TASKS-1:0] cmd_valid,
    input wire logic [NUM_TASKS-1:0][mmq_pkg::TYPE_W-1:0] cmd_type,
    input wire logic [NUM_TASKS-1:0][NUM_AXES-1:0] cmd_axes,
    input wire logic [NUM_TASKS-1:0][NUM_AXES-1:0][mmq_pkg::TARGET_W-1:0] cmd_target,
    input wire logic [NUM_AXES-1:0][mmq_pkg::SPEED_W-1:0] axis_speed,
    input wire logic [NUM_AXES-1:0] axis_halt,
    output logic [NUM_TASKS-1:0] task_queue_full,
    output logic [NUM_AXES-1:0][mmq_pkg::TYPE_W-1:0] active_move_type,
    output logic [NUM_AXES-1:0][mmq_pkg::TYPE_W-1:0] queued_move_type,
    output logic [NUM_AXES-1:0][mmq_pkg::POS_W-1:0] axis_position,
    output logic servo_tick
);
    localparam int TW = mmq_pkg::TYPE_W;
    localparam int EW = mmq_pkg::EDGE_W;
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam int TASK_W = (NUM_TASKS > 1) ? $clog2(NUM_TASKS) : 1;
    localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);

    // Ring pointer advance that wraps at any depth
    function automatic logic [PTR_W-1:0] ptr_add(input logic [PTR_W-1:0] p,
                                                 input logic [CNT_W-1:0] n);
        int s;
        s = int'(p) + int'(n);
        if (s >= DEPTH)
        begin
            s = s - DEPTH;
        end
        return PTR_W'(s);
    endfunction

    // Per task move buffers
    logic [TW-1:0] tq_type [NUM_TASKS][DEPTH];
    logic [NUM_AXES-1:0] tq_mask [NUM_TASKS][DEPTH];
    logic [NUM_AXES-1:0][EW-1:0] tq_edges [NUM_TASKS][DEPTH];
    logic [PTR_W-1:0] tq_head [NUM_TASKS];
    logic [CNT_W-1:0] tq_count [NUM_TASKS];
    logic [NUM_TASKS-1:0] accept;
    logic [NUM_TASKS-1:0] pop;

    // Queued stage per axis
    logic [NUM_AXES-1:0] nq_valid;
    logic [NUM_AXES-1:0] nq_mask [NUM_AXES];
    logic [EW-1:0] nq_edges [NUM_AXES];

    // Active stage status from the axis engines
    logic [NUM_AXES-1:0] act_busy;
    logic [NUM_AXES-1:0] act_done;
    logic [NUM_AXES-1:0] load_now;

    // Sequencing choice
    logic seq_hit;
    logic [TASK_W-1:0] seq_task;
    logic [TW-1:0] sel_type;
    logic [NUM_AXES-1:0] sel_mask;
    logic [NUM_AXES-1:0][EW-1:0] sel_edges;

    mmq_pkg::mmq_state_e state;
    mmq_pkg::mmq_state_e next_state;
    logic tick;

    mmq_axis_if ax [NUM_AXES] ();

    // Servo period source
    mmq_tick #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk(clk),
        .rst(rst),
        .tick(tick)
    );

    assign servo_tick = tick;

    // Phase order within a tick: sequencing, then move loading, then running
    always_comb
    begin
        case (state)
            mmq_pkg::S_IDLE: next_state = tick ? mmq_pkg::S_SEQ : mmq_pkg::S_IDLE;
            mmq_pkg::S_SEQ: next_state = mmq_pkg::S_LOAD;
            mmq_pkg::S_LOAD: next_state = mmq_pkg::S_RUN;
            mmq_pkg::S_RUN: next_state = mmq_pkg::S_IDLE;
            default: next_state = mmq_pkg::S_IDLE;
        endcase
    end

    // Phase register
    always_ff @(posedge clk)
    begin
        if (rst)
            state <= mmq_pkg::S_IDLE;
        else
            state <= next_state;
    end

    // Commands are taken only while the task has room; a full task stalls
    always_comb
    begin
        for (int t = 0; t < NUM_TASKS; t++)
        begin
            accept[t] = cmd_valid[t] && !task_queue_full[t];
            pop[t] = (state == mmq_pkg::S_SEQ) && seq_hit && (seq_task == TASK_W'(t));
        end
    end

    // Lowest numbered task whose head move finds all its queued stages free
    always_comb
    begin
        seq_hit = 1'h0;
        seq_task = '0;
        for (int t = NUM_TASKS - 1; t >= 0; t--)
        begin
            if ((tq_count[t] != '0) && ((tq_mask[t][tq_head[t]] & nq_valid) == '0))
            begin
                seq_hit = 1'h1;
                seq_task = TASK_W'(t);
            end
        end
        sel_type = tq_type[seq_task][tq_head[seq_task]];
        sel_mask = tq_mask[seq_task][tq_head[seq_task]];
        sel_edges = tq_edges[seq_task][tq_head[seq_task]];
    end

    // Task buffers: write at the tail, free the head once sequenced
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int t = 0; t < NUM_TASKS; t++)
            begin
                tq_head[t] <= '0;
                tq_count[t] <= '0;
                task_queue_full[t] <= 1'h0;
            end
        end
        else
        begin
            for (int t = 0; t < NUM_TASKS; t++)
            begin
                if (pop[t])
                    tq_head[t] <= ptr_add(tq_head[t], CNT_W'(1));
                tq_count[t] <= tq_count[t] + CNT_W'(accept[t]) - CNT_W'(pop[t]);
                task_queue_full[t] <=
                    (tq_count[t] + CNT_W'(accept[t]) - CNT_W'(pop[t])) == FULL_COUNT;
            end
        end
    end

    // Buffer contents, converted to encoder edges on entry
    always_ff @(posedge clk)
    begin
        for (int t = 0; t < NUM_TASKS; t++)
        begin
            if (accept[t])
            begin
                tq_type[t][ptr_add(tq_head[t], tq_count[t])] <= cmd_type[t];
                tq_mask[t][ptr_add(tq_head[t], tq_count[t])] <= cmd_axes[t];
                for (int a = 0; a < NUM_AXES; a++)
                begin
                    tq_edges[t][ptr_add(tq_head[t], tq_count[t])][a] <=
                        mmq_pkg::to_edges(cmd_target[t][a]);
                end
            end
        end
    end

    // Queued stage: filled for all axes of a move at once, freed on loading
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            nq_valid <= '0;
            for (int a = 0; a < NUM_AXES; a++)
            begin
                queued_move_type[a] <= mmq_pkg::MT_IDLE;
                nq_mask[a] <= '0;
                nq_edges[a] <= '0;
            end
        end
        else
        begin
            for (int a = 0; a < NUM_AXES; a++)
            begin
                if ((state == mmq_pkg::S_SEQ) && seq_hit && sel_mask[a])
                begin
                    nq_valid[a] <= 1'h1;
                    queued_move_type[a] <= sel_type;
                    nq_mask[a] <= sel_mask;
                    nq_edges[a] <= sel_edges[a];
                end
                else if (load_now[a])
                begin
                    nq_valid[a] <= 1'h0;
                    queued_move_type[a] <= mmq_pkg::MT_IDLE;
                end
            end
        end
    end

    // A queued move loads only when every axis it uses has ended its move
    always_comb
    begin
        for (int a = 0; a < NUM_AXES; a++)
        begin
            load_now[a] = (state == mmq_pkg::S_LOAD) && nq_valid[a]
                          && ((nq_mask[a] & act_busy) == '0);
        end
    end

    // Code of the executing move, back to idle when it completes
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int a = 0; a < NUM_AXES; a++)
                active_move_type[a] <= mmq_pkg::MT_IDLE;
        end
        else
        begin
            for (int a = 0; a < NUM_AXES; a++)
            begin
                if (load_now[a])
                    active_move_type[a] <= queued_move_type[a];
                else if (act_done[a])
                    active_move_type[a] <= mmq_pkg::MT_IDLE;
            end
        end
    end

    // One engine per axis holds the active stage and runs on its own speed
    for (genvar g = 0; g < NUM_AXES; g++)
    begin : g_axis
        assign ax[g].load = load_now[g];
        assign ax[g].continuous = mmq_pkg::is_continuous(queued_move_type[g]);
        assign ax[g].edges = (queued_move_type[g] == mmq_pkg::MT_FORWARD) ? EW'(1) :
                             (queued_move_type[g] == mmq_pkg::MT_REVERSE) ? '1 :
                             nq_edges[g];
        assign ax[g].step = (state == mmq_pkg::S_RUN);
        assign ax[g].halt = axis_halt[g];
        assign ax[g].speed = axis_speed[g];
        assign act_busy[g] = ax[g].busy;
        assign act_done[g] = ax[g].done;
        assign axis_position[g] = ax[g].position;

        mmq_axis u_axis (
            .clk(clk),
            .rst(rst),
            .port(ax[g])
        );
    end
endmodule

// ===== mmq_sequencer_monitor.sv
`timescale 1ns/10ps
module mmq_sequencer_monitor
#(
    parameter int NUM_TASKS = mmq_pkg::NUM_TASKS,
    parameter int NUM_AXES = mmq_pkg::NUM_AXES,
    parameter int TICK_CYCLES = mmq_pkg::TICK_CYCLES
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [NUM_TASKS-1:0] cmd_valid,
    input wire logic [NUM_AXES-1:0] axis_halt,
    input wire logic [NUM_TASKS-1:0] task_queue_full,
    input wire logic [NUM_AXES-1:0][mmq_pkg::TYPE_W-1:0] active_move_type,
    input wire logic [NUM_AXES-1:0][mmq_pkg::TYPE_W-1:0] queued_move_type,
    input wire logic [NUM_AXES-1:0][mmq_pkg::POS_W-1:0] axis_position,
    input wire logic servo_tick
);
    // All checks share one clock, and all but the reset check share one reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Reset empties every stage and flag
    property p_reset_idle;
        disable iff (1'b0)
        rst |=> task_queue_full == '0 && active_move_type == '0 && queued_move_type == '0;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("stage not idle after reset");

    // Cycles since the last tick pulse, or since reset
    logic [31:0] since_tick;
    always_ff @(posedge clk)
    begin
        if (rst)
            since_tick <= 32'h0000_0000;
        else if (servo_tick)
            since_tick <= 32'h0000_0001;
        else
            since_tick <= since_tick + 32'h0000_0001;
    end

    // Tick pulses keep their period
    property p_tick_period;
        servo_tick |-> since_tick == 32'(TICK_CYCLES);
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("servo tick period wrong");

    // Full flag only rises after an offer
    property p_full_cause;
        $rose(task_queue_full[0]) |-> $past(cmd_valid[0]);
    endproperty
    a_full_cause: assert property (p_full_cause) else $error("full flag rose without offer");

    // Full flag drops only after a sequencing phase
    property p_full_free;
        $fell(task_queue_full[0]) && !$past(rst) |-> $past(servo_tick, 2);
    endproperty
    a_full_free: assert property (p_full_free) else $error("full flag fell off tick");

    // Queued stage fills two cycles after a tick
    property p_queued_seq;
        queued_move_type[0] != '0 && $past(queued_move_type[0]) == '0 && !$past(rst)
            |-> $past(servo_tick, 2);
    endproperty
    a_queued_seq: assert property (p_queued_seq) else $error("queued stage filled off tick");

    // Active stage loads three cycles after a tick
    property p_active_load;
        active_move_type[0] != '0 && $past(active_move_type[0]) == '0 && !$past(rst)
            |-> $past(servo_tick, 3);
    endproperty
    a_active_load: assert property (p_active_load) else $error("active stage loaded off tick");

    // Queued move waits while the active stage is busy
    property p_wait_active;
        active_move_type[0] != '0 && queued_move_type[0] != '0
            |=> queued_move_type[0] == $past(queued_move_type[0]);
    endproperty
    a_wait_active: assert property (p_wait_active) else $error("queued move left early");

    // Forward move keeps running until halted
    property p_forward_holds;
        active_move_type[1] == mmq_pkg::MT_FORWARD && !axis_halt[1]
            |=> active_move_type[1] == mmq_pkg::MT_FORWARD;
    endproperty
    a_forward_holds: assert property (p_forward_holds) else $error("forward move ended");

    // Idle axis does not move
    property p_idle_still;
        active_move_type[0] == '0 |=> $stable(axis_position[0]);
    endproperty
    a_idle_still: assert property (p_idle_still) else $error("idle axis moved");

    // Main scenarios
    c_full_cycle: cover property (task_queue_full[0] ##1 !task_queue_full[0]);
    c_both_stages: cover property (queued_move_type[0] != '0 && active_move_type[0] != '0);
    c_halt: cover property (active_move_type[1] == mmq_pkg::MT_FORWARD ##1 active_move_type[1] == '0);
endmodule

bind mmq_sequencer mmq_sequencer_monitor #(
    .NUM_TASKS(NUM_TASKS),
    .NUM_AXES(NUM_AXES),
    .TICK_CYCLES(TICK_CYCLES)
) u_monitor (
    .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .axis_halt(axis_halt),
    .task_queue_full(task_queue_full), .active_move_type(active_move_type),
    .queued_move_type(queued_move_type), .axis_position(axis_position),
    .servo_tick(servo_tick)
);

// ===== mmq_task_model.sv
`timescale 1ns/10ps
module mmq_task_model
#(
    parameter int NUM_TASKS = mmq_pkg::NUM_TASKS,
    parameter int NUM_AXES = mmq_pkg::NUM_AXES
)
(
    input wire logic clk,
    input wire logic [NUM_TASKS-1:0] task_queue_full,
    output logic [NUM_TASKS-1:0] cmd_valid,
    output logic [NUM_TASKS-1:0][mmq_pkg::TYPE_W-1:0] cmd_type,
    output logic [NUM_TASKS-1:0][NUM_AXES-1:0] cmd_axes,
    output logic [NUM_TASKS-1:0][NUM_AXES-1:0][mmq_pkg::TARGET_W-1:0] cmd_target
);
    // Idle command lines carry junk
    initial
    begin
        cmd_valid = '0;
        cmd_type = '1;
        cmd_axes = '1;
        cmd_target = '1;
    end

    // One program task offers a move and stalls until it is taken
    task automatic issue(input int t, input logic [mmq_pkg::TYPE_W-1:0] ty,
                         input logic [NUM_AXES-1:0] ax,
                         input logic [NUM_AXES-1:0][mmq_pkg::TARGET_W-1:0] tg);
        logic ok;
        @(posedge clk);
        #1;
        cmd_valid[t] = 1'b1;
        cmd_type[t] = ty;
        cmd_axes[t] = ax;
        cmd_target[t] = tg;
        forever
        begin
            ok = !task_queue_full[t];
            @(posedge clk);
            if (ok) break;
            #1;
        end
        #1;
        cmd_valid[t] = 1'b0;
        cmd_type[t] = ~ty;
        cmd_axes[t] = ~ax;
        cmd_target[t] = ~tg;
    endtask
endmodule

// ===== mmq_tick.sv
`timescale 1ns/10ps
module mmq_tick
#(
    parameter int CYCLES = mmq_pkg::TICK_CYCLES
)
(
    input wire logic clk,
    input wire logic rst,
    output logic tick
);
    localparam int CNT_W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
    localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

    logic [CNT_W-1:0] count;

    // Free running divider, one pulse per servo period
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            count <= '0;
            tick <= 1'h0;
        end
        else if (count == LAST)
        begin
            count <= '0;
            tick <= 1'h1;
        end
        else
        begin
            count <= count + CNT_W'(1);
            tick <= 1'h0;
        end
    end
endmodule

// ===== motion_move_queue_sequencer_tb.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_fail++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end
module motion_move_queue_sequencer_tb;
    localparam int TB_TICK = 8;
    localparam int NT = mmq_pkg::NUM_TASKS;
    localparam int NA = mmq_pkg::NUM_AXES;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [NT-1:0] cmd_valid;
    logic [NT-1:0][mmq_pkg::TYPE_W-1:0] cmd_type;
    logic [NT-1:0][NA-1:0] cmd_axes;
    logic [NT-1:0][NA-1:0][mmq_pkg::TARGET_W-1:0] cmd_target;
    logic [NA-1:0][mmq_pkg::SPEED_W-1:0] axis_speed;
    logic [NA-1:0] axis_halt;
    logic [NT-1:0] task_queue_full;
    logic [NA-1:0][mmq_pkg::TYPE_W-1:0] active_move_type;
    logic [NA-1:0][mmq_pkg::TYPE_W-1:0] queued_move_type;
    logic [NA-1:0][mmq_pkg::POS_W-1:0] axis_position;
    logic servo_tick;
    logic [NA-1:0][31:0] tg;
    logic [31:0] p1;
    int n_fail = 0;
    int check_count = 0;
    int seed = 80680;
    int exp_pos [NA];

    mmq_sequencer #(.TICK_CYCLES(TB_TICK)) dut (
        .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_type(cmd_type),
        .cmd_axes(cmd_axes), .cmd_target(cmd_target), .axis_speed(axis_speed),
        .axis_halt(axis_halt), .task_queue_full(task_queue_full),
        .active_move_type(active_move_type), .queued_move_type(queued_move_type),
        .axis_position(axis_position), .servo_tick(servo_tick)
    );

    mmq_task_model part (
        .clk(clk), .task_queue_full(task_queue_full), .cmd_valid(cmd_valid),
        .cmd_type(cmd_type), .cmd_axes(cmd_axes), .cmd_target(cmd_target)
    );

    // Whole edges, plus one when the fraction is above 0.9
    function automatic int edges(input logic [31:0] t);
        return ($signed(t) >>> 16) + ((int'(t[15:0]) * 10 > 9 * 65536) ? 1 : 0);
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Waits for the next servo tick, bounded
    task automatic wt();
        for (int i = 0; i < 4 * TB_TICK; i++)
        begin
            @(posedge clk);
            #1;
            if (servo_tick === 1'b1) return;
        end
        n_fail++;
    endtask

    task automatic results();
        if (n_fail == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Clock
    initial
    begin
        forever #25 clk = ~clk;
    end

    // Watchdog
    initial
    begin
        repeat (3000) @(posedge clk);
        n_fail++;
        results();
    end

    // Main sequence
    initial
    begin
        axis_speed = '0;
        axis_halt = '0;
        exp_pos = '{default: 0};
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        `CHK(task_queue_full, 5'h00)
        `CHK({active_move_type, queued_move_type}, 64'h0)
        axis_speed[0] = 16'h0002;
        for (int a = 1; a < NA; a++)
            axis_speed[a] = 16'(1 + $unsigned($random(seed)) % 4);
        // Fill task 0, then a third offer stalls
        wt();
        tg = '0;
        tg[0] = 32'h0003_0000;
        exp_pos[0] = edges(tg[0]) + edges(32'h0001_F333) + edges(32'h0001_E666);
        part.issue(0, mmq_pkg::MT_MOVE, 4'h1, tg);
        tg[0] = 32'h0001_F333;
        part.issue(0, mmq_pkg::MT_MOVE, 4'h1, tg);
        `CHK(task_queue_full[0], 1'b1)
        fork
            part.issue(0, mmq_pkg::MT_MOVE, 4'h1, 128'h1_E666);
        join_none
        // Sequencing then loading within one tick
        wt();
        cyc(2);
        `CHK(queued_move_type[0], mmq_pkg::MT_MOVE)
        `CHK(task_queue_full[0], 1'b0)
        cyc(1);
        `CHK(active_move_type[0], mmq_pkg::MT_MOVE)
        `CHK(queued_move_type[0], 8'h00)
        // Next move waits behind the running one
        wt();
        cyc(3);
        `CHK(active_move_type[0], mmq_pkg::MT_MOVE)
        `CHK(queued_move_type[0], mmq_pkg::MT_MOVE)
        cyc(2);
        `CHK(active_move_type[0], 8'h00)
        `CHK(axis_position[0], 32'h0000_0003)
        // Forward on axis 1, two-axis move on axes 2 and 3
        tg = '0;
        part.issue(1, mmq_pkg::MT_FORWARD, 4'h2, tg);
        for (int a = 2; a < NA; a++)
        begin
            tg[a] = {16'($unsigned($random(seed)) % 16), 16'($random(seed))};
            exp_pos[a] = edges(tg[a]);
        end
        part.issue(4, mmq_pkg::MT_MOVE, 4'hC, tg);
        repeat (3) wt();
        `CHK(active_move_type[1], mmq_pkg::MT_FORWARD)
        // A forward move advances by its own speed once per tick
        p1 = axis_position[1];
        wt();
        `CHK(axis_position[1], p1 + 32'(axis_speed[1]))
        repeat (20) wt();
        for (int a = 0; a < NA; a++)
            if (a != 1) `CHK(axis_position[a], 32'(exp_pos[a]))
        axis_halt[1] = 1'b1;
        repeat (2) wt();
        `CHK(active_move_type[1], 8'h00)
        // A halted axis stays where it stopped
        p1 = axis_position[1];
        wt();
        `CHK(axis_position[1], p1)
        results();
    end
endmodule
